// [logic/video_crop_scale_map.vh]
// Register map, field layout, reset values and constants of video_crop_scale.
// Assumes an 8-bit register port and 8-bit luma samples on one pixel clock.
`ifndef VIDEO_CROP_SCALE_MAP_VH
`define VIDEO_CROP_SCALE_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define A_WIN_HI      8'h02
`define A_VOFF_LO     8'h03
`define A_VACT_LO     8'h04
`define A_HOFF_LO     8'h05
`define A_HACT_LO     8'h06
`define A_FILT        8'h80
`define A_VRAT_HI     8'h81
`define A_VRAT_LO     8'h82
`define A_HRAT_HI     8'h83
`define A_HRAT_LO     8'h84
`define A_PBOFF_HI    8'h8b
`define A_PBVOFF_LO   8'h8c
`define A_PBHOFF_LO   8'h8d
`define A_MANCROP     8'hc0
`define A_PBCTL       8'hc1
`define A_STAT_PIX    8'hc2
`define A_STAT_LIN    8'hc3
`define A_PBVRAT_HI   8'hc4
`define A_PBVRAT_LO   8'hc5
`define A_PBHRAT_HI   8'hc6
`define A_PBHRAT_LO   8'hc7

// ----------------------------------------------------------------
// Reset values (full-size NTSC window, unity ratio)
// ----------------------------------------------------------------
`define R_WIN_HI      8'h02
`define R_VOFF_LO     8'h06
`define R_VACT_LO     8'hf0
`define R_HOFF_LO     8'h20
`define R_HACT_LO     8'hd0
`define R_ZERO        8'h00
`define R_RAT         8'hff

// ----------------------------------------------------------------
// Playback control fields and constants
// ----------------------------------------------------------------
`define B_AUTO        0
`define B_DVR         3
`define W_720         10'd720
`define W_704         10'd704
`define W_640         10'd640
`define DDA_MOD       17'h0ffff
`define UNITY         16'hffff
`define HPH_FULL      6'd32
`define VPH_FULL      5'd16
`define LINE_MAX      1024

`endif

// [logic/video_crop_scale.v]
// Crop window, antialias filters and polyphase down-scaler for one video stream.
// Assumes decoder/playback sources on sys_clk with reference pulses and channel ID.
`timescale 1ns/1ps
`include "video_crop_scale_map.vh"

module video_crop_scale (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       src_playback,
  input  wire       pix_valid,
  input  wire [7:0] pix_data,
  input  wire       line_start,
  input  wire       field_start,
  input  wire       chid_valid,
  input  wire [1:0] chid_num,
  input  wire       chid_frame,
  output reg        disp_valid,
  output reg  [7:0] disp_data,
  output reg  [9:0] disp_hpos,
  output reg  [9:0] disp_vpos,
  output reg        rec_valid,
  output reg  [7:0] rec_data
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Modulo-65535 accumulator so unity emits every sample
  function [16:0] dda_step;
    input [15:0] acc;
    input [15:0] ratio;
    reg   [16:0] s;
    reg   [16:0] d;
    begin
      s = {1'b0, acc} + {1'b0, ratio};
      d = s - `DDA_MOD;
      if (s >= `DDA_MOD) begin
        dda_step = {1'b1, d[15:0]};
      end else begin
        dda_step = {1'b0, s[15:0]};
      end
    end
  endfunction

  function [9:0] pb_width;
    input [1:0] sel;
    begin
      case (sel)
        2'd1:    pb_width = `W_704;
        2'd2:    pb_width = `W_640;
        default: pb_width = `W_720;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg  [7:0] win_hi;
  reg  [7:0] voff_lo;
  reg  [7:0] vact_lo;
  reg  [7:0] hoff_lo;
  reg  [7:0] hact_lo;
  reg  [7:0] filt;
  reg  [7:0] vrat_hi;
  reg  [7:0] vrat_lo;
  reg  [7:0] hrat_hi;
  reg  [7:0] hrat_lo;
  reg  [7:0] pboff_hi;
  reg  [7:0] pbvoff_lo;
  reg  [7:0] pbhoff_lo;
  reg  [7:0] mancrop;
  reg  [7:0] pbctl;
  reg  [7:0] pbvrat_hi;
  reg  [7:0] pbvrat_lo;
  reg  [7:0] pbhrat_hi;
  reg  [7:0] pbhrat_lo;
  reg  [9:0] stat_pix;
  reg  [9:0] stat_lin;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      win_hi    <= `R_WIN_HI;
      voff_lo   <= `R_VOFF_LO;
      vact_lo   <= `R_VACT_LO;
      hoff_lo   <= `R_HOFF_LO;
      hact_lo   <= `R_HACT_LO;
      filt      <= `R_ZERO;
      vrat_hi   <= `R_RAT;
      vrat_lo   <= `R_RAT;
      hrat_hi   <= `R_RAT;
      hrat_lo   <= `R_RAT;
      pboff_hi  <= `R_ZERO;
      pbvoff_lo <= `R_ZERO;
      pbhoff_lo <= `R_ZERO;
      mancrop   <= `R_ZERO;
      pbctl     <= `R_ZERO;
      pbvrat_hi <= `R_RAT;
      pbvrat_lo <= `R_RAT;
      pbhrat_hi <= `R_RAT;
      pbhrat_lo <= `R_RAT;
    end else if (reg_wr) begin
      case (reg_addr)
        `A_WIN_HI:    win_hi    <= reg_wdata;
        `A_VOFF_LO:   voff_lo   <= reg_wdata;
        `A_VACT_LO:   vact_lo   <= reg_wdata;
        `A_HOFF_LO:   hoff_lo   <= reg_wdata;
        `A_HACT_LO:   hact_lo   <= reg_wdata;
        `A_FILT:      filt      <= reg_wdata;
        `A_VRAT_HI:   vrat_hi   <= reg_wdata;
        `A_VRAT_LO:   vrat_lo   <= reg_wdata;
        `A_HRAT_HI:   hrat_hi   <= reg_wdata;
        `A_HRAT_LO:   hrat_lo   <= reg_wdata;
        `A_PBOFF_HI:  pboff_hi  <= reg_wdata;
        `A_PBVOFF_LO: pbvoff_lo <= reg_wdata;
        `A_PBHOFF_LO: pbhoff_lo <= reg_wdata;
        `A_MANCROP:   mancrop   <= reg_wdata;
        `A_PBCTL:     pbctl     <= reg_wdata;
        `A_PBVRAT_HI: pbvrat_hi <= reg_wdata;
        `A_PBVRAT_LO: pbvrat_lo <= reg_wdata;
        `A_PBHRAT_HI: pbhrat_hi <= reg_wdata;
        `A_PBHRAT_LO: pbhrat_lo <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= `R_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `A_WIN_HI:    reg_rdata <= win_hi;
        `A_VOFF_LO:   reg_rdata <= voff_lo;
        `A_VACT_LO:   reg_rdata <= vact_lo;
        `A_HOFF_LO:   reg_rdata <= hoff_lo;
        `A_HACT_LO:   reg_rdata <= hact_lo;
        `A_FILT:      reg_rdata <= filt;
        `A_VRAT_HI:   reg_rdata <= vrat_hi;
        `A_VRAT_LO:   reg_rdata <= vrat_lo;
        `A_HRAT_HI:   reg_rdata <= hrat_hi;
        `A_HRAT_LO:   reg_rdata <= hrat_lo;
        `A_PBOFF_HI:  reg_rdata <= pboff_hi;
        `A_PBVOFF_LO: reg_rdata <= pbvoff_lo;
        `A_PBHOFF_LO: reg_rdata <= pbhoff_lo;
        `A_MANCROP:   reg_rdata <= mancrop;
        `A_PBCTL:     reg_rdata <= pbctl;
        `A_STAT_PIX:  reg_rdata <= stat_pix[7:0];
        `A_STAT_LIN:  reg_rdata <= stat_lin[7:0];
        `A_PBVRAT_HI: reg_rdata <= pbvrat_hi;
        `A_PBVRAT_LO: reg_rdata <= pbvrat_lo;
        `A_PBHRAT_HI: reg_rdata <= pbhrat_hi;
        `A_PBHRAT_LO: reg_rdata <= pbhrat_lo;
        default:      reg_rdata <= `R_ZERO;
      endcase
    end else begin
      reg_rdata <= `R_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Window selection
  // ----------------------------------------------------------------
  wire [9:0] live_hoff = {win_hi[3:2], hoff_lo};
  wire [9:0] live_hact = {win_hi[1:0], hact_lo};
  wire [9:0] live_voff = {win_hi[7:6], voff_lo};
  wire [9:0] live_vact = {win_hi[5:4], vact_lo};
  wire [9:0] pb_hoff   = {pboff_hi[3:2], pbhoff_lo};
  wire [9:0] pb_voff   = {pboff_hi[7:6], pbvoff_lo};
  wire       pb_auto   = pbctl[`B_AUTO];
  wire [1:0] pb_sel    = pbctl[2:1];
  wire       pb_dvr    = pbctl[`B_DVR];
  wire [9:0] pb_w      = pb_width(pbctl[5:4]);
  wire       man_on    = mancrop[0];
  wire [9:0] add_h     = man_on ? pb_hoff : 10'd0;
  wire [9:0] add_v     = man_on ? pb_voff : 10'd0;
  reg  [9:0] hd;
  reg  [9:0] ha;
  reg  [9:0] vd;
  reg  [9:0] va;
  reg        field_ok;
  reg        frame_hold;

  always @* begin
    hd = live_hoff;
    ha = live_hact;
    vd = live_voff;
    va = live_vact;
    if (src_playback) begin
      if (!pb_auto) begin
        hd = pb_hoff;
        ha = pb_w;
        vd = pb_voff;
      end else if (!pb_dvr) begin
        // Normal record stream: quad picture, channel picks a quadrant
        hd = (pb_sel[0] ? {1'b0, pb_w[9:1]} : 10'd0) + add_h;
        ha = {1'b0, pb_w[9:1]};
        vd = (pb_sel[1] ? {1'b0, live_vact[9:1]} : 10'd0) + add_v;
        va = {1'b0, live_vact[9:1]};
      end else begin
        hd = add_h;
        ha = pb_w;
        vd = add_v;
      end
    end
  end

  // DVR stream: whole fields are time-multiplexed by channel ID
  wire gate = !(src_playback && pb_auto && pb_dvr) || field_ok;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      field_ok   <= 1'b0;
      frame_hold <= 1'b0;
    end else if (chid_valid) begin
      field_ok   <= (chid_num == pb_sel);
      frame_hold <= (chid_num == pb_sel) && chid_frame;
    end else if (field_start) begin
      // Frame mode keeps the second field of a matched frame
      field_ok   <= frame_hold;
      frame_hold <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Ratios and filters
  // ----------------------------------------------------------------
  wire [15:0] hratio = src_playback ? {pbhrat_hi, pbhrat_lo} : {hrat_hi, hrat_lo};
  wire [15:0] vratio = src_playback ? {pbvrat_hi, pbvrat_lo} : {vrat_hi, vrat_lo};
  wire [1:0]  hflt   = filt[1:0];
  wire        vflt   = filt[4];

  // ----------------------------------------------------------------
  // Counters and line control
  // ----------------------------------------------------------------
  reg  [9:0]  h_cnt;
  reg  [9:0]  v_cnt;
  reg  [15:0] hacc;
  reg  [15:0] vacc;
  reg         line_in;
  reg         line_emit;
  reg  [3:0]  vph;
  reg  [9:0]  out_x;
  reg  [9:0]  out_y;
  reg  [7:0]  tap1;
  reg  [7:0]  tap2;
  reg  [7:0]  hprev;
  reg  [7:0]  line_buf [0:`LINE_MAX-1];

  wire [9:0]  nv       = v_cnt + 10'd1;
  wire [10:0] v_end    = {1'b0, vd} + {1'b0, va};
  wire [10:0] h_end    = {1'b0, hd} + {1'b0, ha};
  wire        nv_in    = (nv >= vd) && ({1'b0, nv} < v_end);
  wire [16:0] vstep    = dda_step((nv == vd) ? 16'h0000 : vacc, vratio);
  wire        h_in     = (h_cnt >= hd) && ({1'b0, h_cnt} < h_end);
  wire        take     = pix_valid && h_in && line_in && gate && !line_start && !field_start;
  wire [16:0] hstep    = dda_step(hacc, hratio);
  wire [4:0]  hph      = hstep[15:11];
  wire [9:0]  f_sum2   = {2'b00, pix_data} + {2'b00, tap1};
  wire [9:0]  f_sum3   = {2'b00, pix_data} + {1'b0, tap1, 1'b0} + {2'b00, tap2};
  reg  [7:0]  hf;
  wire [5:0]  hw_cur   = `HPH_FULL - {1'b0, hph};
  wire [13:0] h_mix    = hf * hw_cur + hprev * {1'b0, hph};
  wire [7:0]  hi       = h_mix[12:5];
  wire [7:0]  lb_rd    = line_buf[out_x];
  wire [4:0]  vw_cur   = `VPH_FULL - {1'b0, vph};
  wire [12:0] v_mix    = hi * vw_cur + lb_rd * {1'b0, vph};
  wire [7:0]  vi       = v_mix[11:4];
  wire [8:0]  v_avg    = {1'b0, lb_rd} + {1'b0, hi};
  wire [8:0]  v_aa     = {1'b0, vi} + {1'b0, v_avg[8:1]};
  wire [7:0]  vout     = vflt ? v_aa[8:1] : vi;

  always @* begin
    case (hflt)
      2'd0:    hf = pix_data;
      2'd1:    hf = f_sum2[8:1];
      default: hf = f_sum3[9:2];
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      h_cnt     <= 10'd0;
      v_cnt     <= 10'd0;
      hacc      <= 16'h0000;
      vacc      <= 16'h0000;
      line_in   <= 1'b0;
      line_emit <= 1'b0;
      vph       <= 4'd0;
      out_x     <= 10'd0;
      out_y     <= 10'd0;
      tap1      <= 8'h00;
      tap2      <= 8'h00;
      hprev     <= 8'h00;
      stat_pix  <= 10'd0;
      stat_lin  <= 10'd0;
    end else if (field_start) begin
      v_cnt     <= 10'h3ff;
      line_in   <= 1'b0;
      line_emit <= 1'b0;
      stat_lin  <= out_y + {9'd0, line_emit};
      out_y     <= 10'd0;
      vacc      <= 16'h0000;
    end else if (line_start) begin
      h_cnt     <= 10'd0;
      hacc      <= 16'h0000;
      tap1      <= 8'h00;
      tap2      <= 8'h00;
      hprev     <= 8'h00;
      out_x     <= 10'd0;
      v_cnt     <= nv;
      if (line_in) begin
        stat_pix <= out_x;
      end
      if (line_emit) begin
        out_y <= out_y + 10'd1;
      end
      line_in <= nv_in;
      if (nv_in) begin
        vacc      <= vstep[15:0];
        line_emit <= vstep[16];
        vph       <= vstep[15:12];
      end else begin
        line_emit <= 1'b0;
      end
    end else if (pix_valid) begin
      h_cnt <= h_cnt + 10'd1;
      if (take) begin
        tap1  <= pix_data;
        tap2  <= tap1;
        hprev <= hf;
        hacc  <= hstep[15:0];
        if (hstep[16]) begin
          out_x <= out_x + 10'd1;
        end
      end
    end
  end

  // Previous scaled line; the first window line blends with stale data
  always @(posedge sys_clk) begin
    if (take && hstep[16]) begin
      line_buf[out_x] <= hi;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      disp_valid <= 1'b0;
      disp_data  <= 8'h00;
      disp_hpos  <= 10'd0;
      disp_vpos  <= 10'd0;
      rec_valid  <= 1'b0;
      rec_data   <= 8'h00;
    end else begin
      disp_valid <= take && hstep[16] && line_emit && !line_start && !field_start;
      if (take && hstep[16] && line_emit) begin
        disp_data <= vout;
        disp_hpos <= out_x;
        disp_vpos <= out_y;
      end
      // Record path keeps the cropped window unscaled
      rec_valid <= take && !line_start && !field_start;
      if (take) begin
        rec_data <= pix_data;
      end
    end
  end

endmodule // video_crop_scale

// [testbench/video_crop_scale_asserts.sv]
// Port checker for video_crop_scale.
// Assumes one clock and sync active-low reset.
`timescale 1ns/1ps
module video_crop_scale_asserts (
  input wire       sys_clk,
  input wire       rst_n,
  input wire [7:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       pix_valid,
  input wire       line_start,
  input wire       field_start,
  input wire       disp_valid,
  input wire [9:0] disp_hpos,
  input wire [9:0] disp_vpos,
  input wire       rec_valid,
  input wire [7:0] rec_data
);
  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rec_cause_a: assert property (rec_valid |-> $past(pix_valid) && !$past(line_start) && !$past(field_start))
    else $error("record pixel without taken input");
  disp_in_rec_a: assert property (disp_valid |-> rec_valid)
    else $error("display pixel outside crop");
  hpos_step_a: assert property (disp_valid && $past(disp_valid) |-> disp_hpos == $past(disp_hpos) + 10'h001)
    else $error("column not stepping by one");
  vpos_hold_a: assert property (disp_valid && $past(disp_valid) |-> $stable(disp_vpos))
    else $error("row changed within line");
  hpos_origin_a: assert property (disp_valid && $past(line_start, 2) |-> disp_hpos == 10'h000)
    else $error("first column not zero");
  data_hold_a: assert property (!rec_valid |-> $stable(rec_data))
    else $error("record data moved without pulse");
endmodule // video_crop_scale_asserts

bind video_crop_scale video_crop_scale_asserts u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pix_valid(pix_valid), .line_start(line_start),
  .field_start(field_start), .disp_valid(disp_valid), .disp_hpos(disp_hpos),
  .disp_vpos(disp_vpos), .rec_valid(rec_valid), .rec_data(rec_data));

// [testbench/video_src_model.sv]
// Video source: decoder or playback stream with channel ID.
// Assumes the caller enters send_field just after a clock edge.
`timescale 1ns/1ps
module video_src_model (
  input  wire       sys_clk,
  output reg        pix_valid,
  output reg  [7:0] pix_data,
  output reg        line_start,
  output reg        field_start,
  output reg        chid_valid,
  output reg  [1:0] chid_num,
  output reg        chid_frame
);
  initial begin
    pix_valid = 1'b0;
    pix_data = 8'h00;
    line_start = 1'b0;
    field_start = 1'b0;
    chid_valid = 1'b0;
    chid_num = 2'h0;
    chid_frame = 1'b0;
  end
  // ----
  // One field: reference, optional ID, lines
  // ----
  task automatic send_field(input int nl, input int np, input bit cid,
                            input logic [1:0] cn, input logic cf);
    field_start <= 1'b1;
    @(posedge sys_clk);
    field_start <= 1'b0;
    chid_valid <= cid;
    chid_num <= cn;
    chid_frame <= cf;
    @(posedge sys_clk);
    chid_valid <= 1'b0;
    chid_num <= ~cn; // Released: never leave the old value
    chid_frame <= ~cf;
    for (int l = 0; l < nl; l++) begin
      line_start <= 1'b1;
      @(posedge sys_clk);
      line_start <= 1'b0;
      for (int p = 0; p < np; p++) begin
        pix_valid <= 1'b1;
        pix_data <= 8'((l * 16) + p);
        @(posedge sys_clk);
      end
      pix_valid <= 1'b0;
      pix_data <= ~8'((l * 16) + np - 1);
      repeat (2) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // video_src_model

// [testbench/video_crop_scale_tb_top.sv]
// Self-checking bench for video_crop_scale.
// Assumes the source model and checker compiled first.
`timescale 1ns/1ps
module video_crop_scale_tb_top;
  reg        sys_clk;
  reg        rst_n;
  reg  [7:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        reg_wr;
  reg        reg_rd;
  reg        src_playback;
  wire [7:0] reg_rdata;
  wire       pix_valid;
  wire [7:0] pix_data;
  wire       line_start;
  wire       field_start;
  wire       chid_valid;
  wire [1:0] chid_num;
  wire       chid_frame;
  wire       disp_valid;
  wire [7:0] disp_data;
  wire [9:0] disp_hpos;
  wire [9:0] disp_vpos;
  wire       rec_valid;
  wire [7:0] rec_data;
  int        bad_count, n_tests, rec_n, disp_n, hw, vw, cyc;
  logic [7:0] first_rec;
  logic [7:0] first_disp;
  logic [7:0] ra[12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h80, 8'h81, 8'h84, 8'hc0, 8'hc1, 8'hc6, 8'h07};
  logic [7:0] rv[12] = '{8'h02, 8'h06, 8'hf0, 8'h20, 8'hd0, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
  logic [15:0] rat[4] = '{16'hffff, 16'h7fff, 16'h3fff, 16'h7fff};
  logic [7:0] flt[4] = '{8'h01, 8'h11, 8'h12, 8'h13};
  int        wexp[4] = '{720, 704, 640, 720};
  bit        dvr_cid[6] = '{1, 1, 0, 1, 0, 0};
  bit        dvr_fr[6] = '{0, 0, 0, 1, 0, 0};
  bit        dvr_ok[6] = '{0, 1, 0, 1, 1, 0};
  logic [1:0] dvr_num[6] = '{2'd1, 2'd2, 2'd2, 2'd2, 2'd2, 2'd2};

  video_crop_scale u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_playback(src_playback), .pix_valid(pix_valid), .pix_data(pix_data),
    .line_start(line_start), .field_start(field_start), .chid_valid(chid_valid),
    .chid_num(chid_num), .chid_frame(chid_frame), .disp_valid(disp_valid),
    .disp_data(disp_data), .disp_hpos(disp_hpos), .disp_vpos(disp_vpos),
    .rec_valid(rec_valid), .rec_data(rec_data));
  video_src_model u_src (.sys_clk(sys_clk), .pix_valid(pix_valid), .pix_data(pix_data),
    .line_start(line_start), .field_start(field_start), .chid_valid(chid_valid),
    .chid_num(chid_num), .chid_frame(chid_frame));

  // ----
  // Bus, compare and run helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1; // Held high: back-to-back writes
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic bus_end;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk({24'h0, reg_rdata}, {24'h0, exp}, "read data");
  endtask
  task automatic win(input logic [9:0] ho, input logic [9:0] ha, input logic [9:0] vo, input logic [9:0] va);
    wr(8'h02, {vo[9:8], va[9:8], ho[9:8], ha[9:8]});
    wr(8'h03, vo[7:0]);
    wr(8'h04, va[7:0]);
    wr(8'h05, ho[7:0]);
    wr(8'h06, ha[7:0]);
    bus_end();
  endtask
  task automatic set_rat(input logic [7:0] base, input logic [15:0] r);
    wr(base, r[15:8]);
    wr(base + 8'h01, r[7:0]);
    wr(base + 8'h02, r[15:8]);
    wr(base + 8'h03, r[7:0]);
  endtask
  task automatic run(input int nl, input int np, input bit cid, input logic [1:0] cn, input logic cf);
    rec_n = 0;
    disp_n = 0;
    hw = 0;
    vw = 0;
    u_src.send_field(nl, np, cid, cn, cf);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----
  // Clock, monitor and watchdog
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (rec_valid === 1'b1) begin
      if (rec_n == 0) first_rec = rec_data;
      rec_n++;
    end
    if (disp_valid === 1'b1) begin
      if (disp_n == 0) first_disp = disp_data;
      disp_n++;
      if (int'(disp_hpos) >= hw) hw = int'(disp_hpos) + 1;
      if (int'(disp_vpos) >= vw) vw = int'(disp_vpos) + 1;
    end
    if (cyc == 40000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  // ----
  // Tests
  // ----
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src_playback = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ra[i]) chk_rd(ra[i], rv[i]);
    $display("test reset_values done");
    win(10'd3, 10'd10, 10'd2, 10'd4);
    run(8, 24, 0, 2'd0, 1'b0);
    chk(rec_n, 40, "live crop count");
    chk(disp_n, 40, "unity count");
    chk(hw * 256 + vw, 10 * 256 + 4, "unity size");
    chk({24'h0, first_rec}, 32'h23, "first cropped pixel");
    chk({24'h0, first_disp}, 32'h23, "unity pixel passes unchanged");
    chk_rd(8'hc2, 8'h0a);
    $display("test live_crop done");
    win(10'd0, 10'd20, 10'd1, 10'd8);
    for (int i = 0; i < 4; i++) begin
      set_rat(8'h81, rat[i]);
      wr(8'h80, flt[i]);
      bus_end();
      run(10, 24, 0, 2'd0, 1'b0);
      chk(rec_n, 160, "window kept under scaling");
      chk(hw, (20 * rat[i]) / 65535, "scaled width");
      if (i == 0) chk({24'h0, first_disp}, 32'h08, "averaged first pixel");
      chk(disp_n, ((20 * rat[i]) / 65535) * ((8 * rat[i]) / 65535), "scaled count");
    end
    $display("test live_scale done");
    src_playback <= 1'b1;
    set_rat(8'h81, 16'h3fff);
    wr(8'h8b, 8'h00);
    wr(8'h8c, 8'h01);
    wr(8'h8d, 8'h04);
    win(10'd0, 10'd20, 10'd1, 10'd1);
    for (int w = 0; w < 4; w++) begin
      wr(8'hc1, 8'(w << 4));
      bus_end();
      run(3, 730, 0, 2'd0, 1'b0);
      chk(rec_n, wexp[w], "playback width");
      chk(disp_n, wexp[w], "playback ratio bank");
      if (w == 0) chk({24'h0, first_rec}, 32'h14, "playback offset");
    end
    $display("test playback_manual done");
    wr(8'hc1, 8'h0d);
    bus_end();
    for (int k = 0; k < 6; k++) begin
      run(4, 24, dvr_cid[k], dvr_num[k], dvr_fr[k]);
      chk(rec_n > 0, dvr_ok[k], "channel match");
    end
    $display("test playback_auto done");
    // Normal record stream: lower-left quadrant, with and without manual offsets
    wr(8'hc1, 8'h05);
    wr(8'hc0, 8'h01);
    win(10'd0, 10'd20, 10'd0, 10'd4);
    for (int m = 0; m < 2; m++) begin
      run(6, 24, 0, 2'd0, 1'b0);
      chk(rec_n, 40 + m * 8, "quadrant count");
      chk({24'h0, first_rec}, m ? 32'h20 : 32'h34, "quadrant origin");
      wr(8'hc0, 8'h00);
      bus_end();
    end
    $display("test playback_quadrant done");
    conclude();
  end
endmodule // video_crop_scale_tb_top
